// [core/fsr_cycle_timer.sv]
// Down counter that flags when a loaded cycle count has elapsed
`timescale 1ns/10ps
`default_nettype none

module fsr_cycle_timer (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        load,
    input  wire logic [15:0] limit,
    output logic             expired_ff
);

    logic [15:0] count_ff;
    logic [15:0] nxt_count;
    logic        nxt_expired;

    always_comb begin
        nxt_count = count_ff;
        if (load) begin
            nxt_count = limit;
        end else if (count_ff != 16'h0000) begin
            nxt_count = count_ff - 16'h0001;
        end
        nxt_expired = (nxt_count == 16'h0000);
    end

    // Idle timer reads expired so that no wait is imposed after reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_ff   <= 16'h0000;
            expired_ff <= 1'b1;
        end else begin
            count_ff   <= nxt_count;
            expired_ff <= nxt_expired;
        end
    end

endmodule
`default_nettype wire

// [core/fsr_defs.svh]
// Constants for the suspend and resume sequencer of the embedded erase and program engine
// Notes on behaviour
// - Erase suspend latency unit reads 10b, 8us
// - Erase halts within 40us after suspend
// - Program suspend latency unit reads 10b, 8us
// - Program halts within 40us after suspend
// - Erase-suspend prohibition field reads 1100b
// - Program-suspend prohibition field reads 1100b
// - Byte 75h suspends an erase
// - Byte 7Ah resumes the suspended erase
// - Same 75h and 7Ah codes for program
`ifndef FSR_DEFS_SVH
`define FSR_DEFS_SVH

`define FSR_CMD_SUSPEND     8'h75
`define FSR_CMD_RESUME      8'h7a

`define FSR_CLK_PERIOD_NS   5
`define FSR_SUSP_LAT_US     40
`define FSR_RESUME_GAP_US   128
// Longest time rounds down, least time rounds up
`define FSR_SUSP_LAT_CYC    ((`FSR_SUSP_LAT_US * 1000) / `FSR_CLK_PERIOD_NS)
`define FSR_RESUME_GAP_CYC  ((`FSR_RESUME_GAP_US * 1000 + `FSR_CLK_PERIOD_NS - 1) / `FSR_CLK_PERIOD_NS)

// Suspend field layout of the parameter dword
`define FSR_SUSP_SUPP_BIT   31
`define FSR_ERS_UNIT_MSB    30
`define FSR_ERS_UNIT_LSB    29
`define FSR_PRG_UNIT_MSB    19
`define FSR_PRG_UNIT_LSB    18
`define FSR_ERS_PROH_MSB    7
`define FSR_ERS_PROH_LSB    4
`define FSR_PRG_PROH_MSB    3
`define FSR_PRG_PROH_LSB    0

`define FSR_SUSP_SUPP       1'b0
`define FSR_UNIT_8US        2'b10
`define FSR_LAT_COUNT       5'b00100
`define FSR_GAP_COUNT       4'b0001
`define FSR_RFU_BIT         1'b1
`define FSR_PROH_VALUE      4'b1100
`define FSR_DWORD_RST       {`FSR_SUSP_SUPP, `FSR_UNIT_8US, `FSR_LAT_COUNT, `FSR_GAP_COUNT, \
                             `FSR_UNIT_8US, `FSR_LAT_COUNT, `FSR_GAP_COUNT, `FSR_RFU_BIT, \
                             `FSR_PROH_VALUE, `FSR_PROH_VALUE}

`endif

// [core/fsr_pkg.sv]
// Types shared by the suspend and resume sequencer
package fsr_pkg;

    typedef enum logic [1:0] {
        FSR_IDLE = 2'b00,
        FSR_BUSY = 2'b01,
        FSR_HALT = 2'b11,
        FSR_SUSP = 2'b10
    } fsr_state_e;

    typedef enum logic {
        FSR_OP_ERASE = 1'b0,
        FSR_OP_PROG  = 1'b1
    } fsr_op_e;

endpackage

// [core/fsr_sequencer.sv]
// Suspend and resume sequencer for the embedded erase and program engine
`timescale 1ns/10ps
`default_nettype none
`include "fsr_defs.svh"

module fsr_sequencer
    import fsr_pkg::*;
#(
    parameter logic [15:0] SUSP_LAT_CYC   = 16'(`FSR_SUSP_LAT_CYC),
    parameter logic [15:0] RESUME_GAP_CYC = 16'(`FSR_RESUME_GAP_CYC)
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        cmd_valid,
    input  wire logic [7:0]  cmd_byte,
    input  wire logic        erase_start,
    input  wire logic        prog_start,
    input  wire logic        op_done,
    input  wire logic        algo_safe,
    input  wire logic        read_req,
    input  wire logic        read_in_susp_sector,
    output logic             algo_run_ff,
    output logic             erase_busy_ff,
    output logic             prog_busy_ff,
    output logic             erase_susp_ff,
    output logic             prog_susp_ff,
    output logic             suspend_ack_ff,
    output logic             host_fault_ff,
    output logic [31:0]      param_dword_ff
);

    fsr_state_e  state_ff;
    fsr_state_e  nxt_state;
    fsr_op_e     op_ff;
    fsr_op_e     nxt_op;
    logic        nxt_algo_run;
    logic        nxt_erase_busy;
    logic        nxt_prog_busy;
    logic        nxt_erase_susp;
    logic        nxt_prog_susp;
    logic        nxt_suspend_ack;
    logic        nxt_host_fault;
    logic        suspend_cmd;
    logic        resume_cmd;
    logic        halt_load;
    logic        halt_expired;
    logic        gap_load;
    logic        gap_expired;
    logic [15:0] halt_limit;
    logic [15:0] gap_limit;

    assign suspend_cmd = cmd_valid && (cmd_byte == `FSR_CMD_SUSPEND);
    assign resume_cmd  = cmd_valid && (cmd_byte == `FSR_CMD_RESUME);

    // Two cycles are spent taking the command and leaving the halt state
    assign halt_limit = SUSP_LAT_CYC - 16'h0002;

    // Timer reads expired on the edge it reaches zero, sampled one edge later; a suspend exactly at the gap is legal
    assign gap_limit = RESUME_GAP_CYC - 16'h0001;

    fsr_cycle_timer u_halt_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .load       (halt_load),
        .limit      (halt_limit),
        .expired_ff (halt_expired)
    );

    fsr_cycle_timer u_gap_timer (
        .clk        (clk),
        .reset_n    (reset_n),
        .load       (gap_load),
        .limit      (gap_limit),
        .expired_ff (gap_expired)
    );

    always_comb begin
        nxt_state       = state_ff;
        nxt_op          = op_ff;
        nxt_suspend_ack = 1'b0;
        nxt_host_fault  = 1'b0;
        halt_load       = 1'b0;
        gap_load        = 1'b0;
        case (state_ff)
            FSR_IDLE: begin
                if (erase_start) begin
                    nxt_state = FSR_BUSY;
                    nxt_op    = FSR_OP_ERASE;
                end else if (prog_start) begin
                    nxt_state = FSR_BUSY;
                    nxt_op    = FSR_OP_PROG;
                end
            end
            FSR_BUSY: begin
                if (op_done) begin
                    nxt_state = FSR_IDLE;
                end else if (suspend_cmd) begin
                    nxt_state = FSR_HALT;
                    halt_load = 1'b1;
                    // Honoured anyway; an early suspend only costs progress
                    nxt_host_fault = !gap_expired;
                end
            end
            FSR_HALT: begin
                // Timer forces the halt if no safe point comes in time
                if (op_done) begin
                    nxt_state = FSR_IDLE;
                end else if (algo_safe || halt_expired) begin
                    nxt_state       = FSR_SUSP;
                    nxt_suspend_ack = 1'b1;
                end
            end
            FSR_SUSP: begin
                if (resume_cmd) begin
                    nxt_state = FSR_BUSY;
                    gap_load  = 1'b1;
                end
                // Prohibited starts are dropped and reported
                if (erase_start) begin
                    nxt_host_fault = 1'b1;
                end
                if (prog_start && op_ff == FSR_OP_PROG) begin
                    nxt_host_fault = 1'b1;
                end
                if (read_req && read_in_susp_sector && op_ff == FSR_OP_ERASE) begin
                    nxt_host_fault = 1'b1;
                end
            end
            default: begin
                nxt_state = FSR_IDLE;
            end
        endcase
        nxt_algo_run   = (nxt_state == FSR_BUSY) || (nxt_state == FSR_HALT);
        nxt_erase_busy = nxt_algo_run && (nxt_op == FSR_OP_ERASE);
        nxt_prog_busy  = nxt_algo_run && (nxt_op == FSR_OP_PROG);
        nxt_erase_susp = (nxt_state == FSR_SUSP) && (nxt_op == FSR_OP_ERASE);
        nxt_prog_susp  = (nxt_state == FSR_SUSP) && (nxt_op == FSR_OP_PROG);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_ff       <= FSR_IDLE;
            op_ff          <= FSR_OP_ERASE;
            algo_run_ff    <= 1'b0;
            erase_busy_ff  <= 1'b0;
            prog_busy_ff   <= 1'b0;
            erase_susp_ff  <= 1'b0;
            prog_susp_ff   <= 1'b0;
            suspend_ack_ff <= 1'b0;
            host_fault_ff  <= 1'b0;
        end else begin
            state_ff       <= nxt_state;
            op_ff          <= nxt_op;
            algo_run_ff    <= nxt_algo_run;
            erase_busy_ff  <= nxt_erase_busy;
            prog_busy_ff   <= nxt_prog_busy;
            erase_susp_ff  <= nxt_erase_susp;
            prog_susp_ff   <= nxt_prog_susp;
            suspend_ack_ff <= nxt_suspend_ack;
            host_fault_ff  <= nxt_host_fault;
        end
    end

    // Advertised suspend timing and prohibition fields, fixed in hardware
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            param_dword_ff <= `FSR_DWORD_RST;
        end else begin
            param_dword_ff <= param_dword_ff;
        end
    end

    // Cycles spent since the suspend command was taken
    logic [15:0] halt_cnt_ff;
    logic [15:0] nxt_halt_cnt;

    always_comb begin
        nxt_halt_cnt = 16'h0000;
        if (state_ff == FSR_HALT) begin
            nxt_halt_cnt = halt_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            halt_cnt_ff <= 16'h0000;
        end else begin
            halt_cnt_ff <= nxt_halt_cnt;
        end
    end

    erase_unit_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ##1 param_dword_ff[`FSR_ERS_UNIT_MSB:`FSR_ERS_UNIT_LSB] == 2'b10)
        else $error("erase latency unit field wrong");

    prog_unit_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ##1 param_dword_ff[`FSR_PRG_UNIT_MSB:`FSR_PRG_UNIT_LSB] == 2'b10)
        else $error("program latency unit field wrong");

    erase_prohib_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ##1 param_dword_ff[`FSR_ERS_PROH_MSB:`FSR_ERS_PROH_LSB] == 4'hc)
        else $error("erase suspend prohibition field wrong");

    prog_prohib_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        ##1 param_dword_ff[`FSR_PRG_PROH_MSB:`FSR_PRG_PROH_LSB] == 4'hc)
        else $error("program suspend prohibition field wrong");

    erase_halt_bound_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == FSR_HALT && op_ff == FSR_OP_ERASE) |-> (halt_cnt_ff < SUSP_LAT_CYC - 16'h0001))
        else $error("erase not halted within latency limit");

    prog_halt_bound_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == FSR_HALT && op_ff == FSR_OP_PROG) |-> (halt_cnt_ff < SUSP_LAT_CYC - 16'h0001))
        else $error("program not halted within latency limit");

    suspend_take_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == FSR_BUSY && suspend_cmd && !op_done) |=> (state_ff == FSR_HALT && algo_run_ff))
        else $error("suspend command not taken while busy");

    suspend_ack_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        $rose(suspend_ack_ff) |-> !algo_run_ff && (erase_susp_ff != prog_susp_ff))
        else $error("suspend acknowledge without halted operation");

    resume_run_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == FSR_SUSP && resume_cmd) |=> algo_run_ff && $past(op_ff) == op_ff
            && (erase_busy_ff == $past(erase_susp_ff)))
        else $error("resume did not continue the suspended operation");

    prohib_start_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        (state_ff == FSR_SUSP && erase_start && !resume_cmd) |=> (state_ff == FSR_SUSP && host_fault_ff))
        else $error("erase start during suspend not refused");

endmodule
`default_nettype wire

// [verification/fsr_host_model.sv]
// Host controller model that issues suspend, resume, start and read requests
`timescale 1ns/10ps
`default_nettype none

module fsr_host_model #(
    parameter int GAP = 40
) (
    input  wire logic       clk,
    input  wire logic       erase_susp,
    input  wire logic       prog_susp,
    output logic            cmd_valid,
    output logic [7:0]      cmd_byte,
    output logic            erase_start,
    output logic            prog_start,
    output logic            read_req,
    output logic            read_in_susp_sector
);
    int cyc = 0;
    int t_res = -100000;

    initial begin
        cmd_valid = 1'b0;
        cmd_byte = 8'h00;
        erase_start = 1'b0;
        prog_start = 1'b0;
        read_req = 1'b0;
        read_in_susp_sector = 1'b0;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
    end

    // A polite host honours the resume-to-suspend gap; early is for host-fault tests
    // Two edges go to driving the byte, so a polite suspend lands exactly at the gap
    task send(input logic [7:0] b, input bit early);
        while (b == 8'h75 && !early && cyc - t_res < GAP - 2) @(posedge clk);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_byte <= b;
        @(posedge clk);
        cmd_valid <= 1'b0;
        cmd_byte <= ~b;
        if (b == 8'h7a) t_res = cyc;
    endtask

    task start(input bit erase, input bit bad);
        if (!bad && (erase_susp || prog_susp)) return;
        @(posedge clk);
        erase_start <= erase;
        prog_start <= !erase;
        @(posedge clk);
        erase_start <= 1'b0;
        prog_start <= 1'b0;
    endtask

    task read(input bit in_sec, input bit bad);
        if (!bad && in_sec && erase_susp) return;
        @(posedge clk);
        read_req <= 1'b1;
        read_in_susp_sector <= in_sec;
        @(posedge clk);
        read_req <= 1'b0;
        read_in_susp_sector <= !in_sec;
    endtask
endmodule

`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the suspend and resume sequencer
`timescale 1ns/10ps
`default_nettype none

module tb;
    localparam int SLAT = 20;
    localparam int GAP = 40;
    logic clk, reset_n, op_done, algo_safe;
    logic cmd_valid, erase_start, prog_start, read_req, read_sec;
    logic [7:0] cmd_byte;
    logic algo_run, erase_busy, prog_busy, erase_susp, prog_susp, ack, fault;
    logic [31:0] dword;
    int mismatches = 0;
    int compares = 0;
    int faults = 0;
    int cyc_cnt = 0;

    fsr_sequencer #(.SUSP_LAT_CYC(16'(SLAT)), .RESUME_GAP_CYC(16'(GAP))) DUT (
        .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte),
        .erase_start(erase_start), .prog_start(prog_start), .op_done(op_done),
        .algo_safe(algo_safe), .read_req(read_req), .read_in_susp_sector(read_sec),
        .algo_run_ff(algo_run), .erase_busy_ff(erase_busy), .prog_busy_ff(prog_busy),
        .erase_susp_ff(erase_susp), .prog_susp_ff(prog_susp), .suspend_ack_ff(ack),
        .host_fault_ff(fault), .param_dword_ff(dword));

    fsr_host_model #(.GAP(GAP)) host (
        .clk(clk), .erase_susp(erase_susp), .prog_susp(prog_susp),
        .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .erase_start(erase_start),
        .prog_start(prog_start), .read_req(read_req), .read_in_susp_sector(read_sec));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (fault === 1'b1) faults++;
        cyc_cnt++;
        if (cyc_cnt == 3000) begin
            mismatches++;
            end_sim();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            mismatches++;
        end
    endtask

    task end_sim;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Edges from the taking edge of a suspend until the acknowledge shows
    task wait_ack(output int n);
        n = 0;
        while (ack !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask

    // Early suspend must flag the host; its halt is waited for but not checked, then the op completes
    task early_and_done(input bit erase);
        int n, f0;
        host.send(8'h7a, 1'b0);
        f0 = faults;
        host.send(8'h75, 1'b1);
        wait_ack(n);
        chk("early suspend fault", 1, faults - f0);
        host.send(8'h7a, 1'b0);
        repeat (2) @(posedge clk);
        chk("busy after resume", {erase, !erase}, {erase_busy, prog_busy});
        op_done <= 1'b1;
        @(posedge clk);
        op_done <= 1'b0;
        repeat (2) @(posedge clk);
        chk("run after done", 0, algo_run);
    endtask

    task t_erase;
        int n, f0;
        algo_safe <= 1'b1;
        host.start(1'b1, 1'b0);
        repeat (2) @(posedge clk);
        chk("erase_busy", 1, erase_busy);
        f0 = faults;
        host.send(8'h75, 1'b0);
        wait_ack(n);
        chk("polite erase suspend fault", 0, faults - f0);
        chk("erase halt in time", 1, n <= SLAT);
        chk("erase_susp run", 2'b10, {erase_susp, algo_run});
        f0 = faults;
        host.start(1'b1, 1'b1);
        host.read(1'b1, 1'b1);
        host.read(1'b0, 1'b0);
        repeat (3) @(posedge clk);
        chk("erase susp faults", 2, faults - f0);
        early_and_done(1'b1);
    endtask

    task t_prog;
        int n, f0;
        algo_safe <= 1'b0;
        host.start(1'b0, 1'b0);
        repeat (2) @(posedge clk);
        chk("prog_busy", 1, prog_busy);
        f0 = faults;
        host.send(8'h75, 1'b0);
        wait_ack(n);
        chk("gap boundary suspend fault", 0, faults - f0);
        chk("prog halt in time", 1, n <= SLAT);
        chk("prog_susp", 1, prog_susp);
        f0 = faults;
        host.start(1'b0, 1'b1);
        host.start(1'b1, 1'b1);
        repeat (3) @(posedge clk);
        chk("prog susp faults", 2, faults - f0);
        chk("no nested start", 0, erase_busy | prog_busy);
        early_and_done(1'b0);
    endtask

    initial begin
        reset_n = 1'b0;
        op_done = 1'b0;
        algo_safe = 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        chk("param dword", 32'h441883cc, dword);
        t_erase();
        t_prog();
        end_sim();
    end
endmodule

`default_nettype wire
